// *** hw/spi_port_pkg.sv ***
package spi_port_pkg;

    // Frame layout.
    localparam int          DATA_W      = 11;
    localparam int          ADDR_W      = 4;
    localparam int          FRAME_W     = 16;
    localparam int          RW_POS      = 15;
    localparam int          ADDR_MSB    = 14;
    localparam int          ADDR_LSB    = 11;
    localparam logic [4:0]  FRAME_BITS  = 5'h10;
    localparam logic [4:0]  CMD_BITS    = 5'h05;
    localparam logic [4:0]  CNT_SAT     = 5'h11;
    localparam logic        RW_WRITE    = 1'h0;

    // Register offsets.
    localparam logic [3:0]  ADDR_FAULT1 = 4'h0;
    localparam logic [3:0]  ADDR_FAULT2 = 4'h1;
    localparam logic [3:0]  ADDR_DRV    = 4'h2;
    localparam logic [3:0]  ADDR_GDHS   = 4'h3;
    localparam logic [3:0]  ADDR_GDLS   = 4'h4;
    localparam logic [3:0]  ADDR_OCP    = 4'h5;
    localparam logic [3:0]  ADDR_CSA    = 4'h6;
    localparam logic [3:0]  ADDR_CAL    = 4'h7;

    // Field positions and codes.
    localparam int          LATCHED_FAULT_CLEAR_POS = 0;
    localparam int          LOCK_MSB    = 10;
    localparam int          LOCK_LSB    = 8;
    localparam logic [2:0]  LOCK_SET    = 3'h6;
    localparam logic [10:0] CAL_MASK    = 11'h001;

    // Values after reset and in sleep.
    localparam logic [10:0] DEF_DRV     = 11'h000;
    localparam logic [10:0] DEF_GDHS    = 11'h000;
    localparam logic [10:0] DEF_GDLS    = 11'h000;
    localparam logic [10:0] DEF_OCP     = 11'h000;
    localparam logic [10:0] DEF_CSA     = 11'h000;
    localparam logic [10:0] DEF_CAL     = 11'h000;

endpackage : spi_port_pkg

// *** hw/spi_reg_bank.sv ***
module spi_reg_bank
    import spi_port_pkg::*;
(
    // Clock and reset.
    input  wire logic              i_clk,
    input  wire logic              i_rstn,
    input  wire logic              i_sleep,
    // Write port.
    input  wire logic              i_wr_en,
    input  wire logic [ADDR_W-1:0] i_wr_addr,
    input  wire logic [DATA_W-1:0] i_wr_data,
    input  wire logic              i_lock_only,
    // Read port.
    input  wire logic [ADDR_W-1:0] i_rd_addr,
    input  wire logic [DATA_W-1:0] i_status1,
    input  wire logic [DATA_W-1:0] i_status2,
    output logic      [DATA_W-1:0] o_rd_data,
    // Stored settings.
    output logic      [DATA_W-1:0] o_drv,
    output logic      [DATA_W-1:0] o_gdhs,
    output logic      [DATA_W-1:0] o_gdls,
    output logic      [DATA_W-1:0] o_ocp,
    output logic      [DATA_W-1:0] o_csa,
    output logic      [DATA_W-1:0] o_cal
);

    logic [DATA_W-1:0] lock_mask;

    // While locked only the lock field itself may change, so it can be opened.
    assign lock_mask = i_lock_only ? 11'h700 : 11'h7ff;

    // Sleep is a synchronous return to defaults; only the pin reset is asynchronous.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_drv  <= DEF_DRV;
            o_gdhs <= DEF_GDHS;
            o_gdls <= DEF_GDLS;
            o_ocp  <= DEF_OCP;
            o_csa  <= DEF_CSA;
            o_cal  <= DEF_CAL;
        end else if (i_sleep) begin
            o_drv  <= DEF_DRV;
            o_gdhs <= DEF_GDHS;
            o_gdls <= DEF_GDLS;
            o_ocp  <= DEF_OCP;
            o_csa  <= DEF_CSA;
            o_cal  <= DEF_CAL;
        end else if (i_wr_en) begin
            case (i_wr_addr)
                ADDR_DRV:  o_drv  <= i_wr_data & ~(11'h001 << LATCHED_FAULT_CLEAR_POS);
                ADDR_GDHS: o_gdhs <= (i_wr_data & lock_mask) | (o_gdhs & ~lock_mask);
                ADDR_GDLS: o_gdls <= i_wr_data;
                ADDR_OCP:  o_ocp  <= i_wr_data;
                ADDR_CSA:  o_csa  <= i_wr_data;
                ADDR_CAL:  o_cal  <= i_wr_data & CAL_MASK;
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rd_data <= 11'h000;
        end else begin
            case (i_rd_addr)
                ADDR_FAULT1: o_rd_data <= i_status1;
                ADDR_FAULT2: o_rd_data <= i_status2;
                ADDR_DRV:    o_rd_data <= o_drv;
                ADDR_GDHS:   o_rd_data <= o_gdhs;
                ADDR_GDLS:   o_rd_data <= o_gdls;
                ADDR_OCP:    o_rd_data <= o_ocp;
                ADDR_CSA:    o_rd_data <= o_csa;
                ADDR_CAL:    o_rd_data <= o_cal;
                default:     o_rd_data <= 11'h000;
            endcase
        end
    end

endmodule : spi_reg_bank

// *** hw/spi_port.sv ***
module spi_port
    import spi_port_pkg::*;
(
    // Clock and reset.
    input  wire logic              i_clk,
    input  wire logic              i_rstn,
    // Device enable pin; low puts the port to sleep.
    input  wire logic              i_enable,
    // Serial pins.
    input  wire logic              i_serial_select_n,
    input  wire logic              i_sclk,
    input  wire logic              i_serial_data_in,
    output logic                   o_serial_data_out,
    output logic                   o_serial_data_out_oe_n,
    // Status inputs from the protection logic.
    input  wire logic [DATA_W-1:0] i_fault_status_primary,
    input  wire logic [DATA_W-1:0] i_gate_fault_status_secondary,
    // Settings and events.
    output logic      [DATA_W-1:0] o_driver_control,
    output logic      [DATA_W-1:0] o_gate_drive_high_side,
    output logic      [DATA_W-1:0] o_gate_drive_low_side,
    output logic      [DATA_W-1:0] o_overcurrent_control,
    output logic      [DATA_W-1:0] o_current_amp_control,
    output logic      [DATA_W-1:0] o_calibration_mode_control,
    output logic                   o_latched_fault_clear,
    output logic                   o_frame_error
);

    typedef enum logic [1:0] {ST_SLEEP, ST_IDLE, ST_FRAME} state_t;

    state_t               st_r;
    logic [2:0]           sclk_q;
    logic [2:0]           sel_q;
    logic [1:0]           sdi_q;
    logic [1:0]           en_q;
    logic [4:0]           cnt_r;
    logic [FRAME_W-1:0]   in_sr_r;
    logic [DATA_W-1:0]    out_sr_r;
    logic                 cap1_r;
    logic                 cap2_r;
    logic                 sdo_rel_r;
    logic                 sdo_low_r;
    logic                 wr_en_r;
    logic [ADDR_W-1:0]    wr_addr_r;
    logic [DATA_W-1:0]    wr_data_r;
    logic                 clr_r;
    logic                 err_r;
    logic [DATA_W-1:0]    rd_data;
    logic                 sclk_fall;
    logic                 sclk_rise;
    logic                 sel_fall;
    logic                 sel_rise;
    logic                 sleep;
    logic                 locked;
    logic                 in_frame;
    logic [ADDR_W-1:0]    f_addr;
    logic                 f_write;
    logic                 f_ok;
    logic                 wr_allow;

    // Pins come from the master's clock domain, so each passes two flops.
    // Bit 0 of every chain is read only by bit 1.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sclk_q <= 3'h0;
            sel_q  <= 3'h7;
            sdi_q  <= 2'h0;
            en_q   <= 2'h0;
        end else begin
            sclk_q <= {sclk_q[1:0], i_sclk};
            sel_q  <= {sel_q[1:0], i_serial_select_n};
            sdi_q  <= {sdi_q[0], i_serial_data_in};
            en_q   <= {en_q[0], i_enable};
        end
    end

    assign sclk_fall = sclk_q[2] & ~sclk_q[1];
    assign sclk_rise = ~sclk_q[2] & sclk_q[1];
    assign sel_fall  = sel_q[2] & ~sel_q[1];
    assign sel_rise  = ~sel_q[2] & sel_q[1];
    assign sleep     = ~en_q[1];
    assign in_frame  = (st_r == ST_FRAME);
    assign locked    = (o_gate_drive_high_side[LOCK_MSB:LOCK_LSB] == LOCK_SET);

    // Decoded fields of the word just received.
    assign f_write  = (in_sr_r[RW_POS] == RW_WRITE);
    assign f_addr   = in_sr_r[ADDR_MSB:ADDR_LSB];
    assign f_ok     = (cnt_r == FRAME_BITS);
    assign wr_allow = (f_addr >= ADDR_DRV) && (f_addr <= ADDR_CAL)
                      && (!locked || f_addr == ADDR_GDHS);

    // Frames start only when the master lowers select; nothing here initiates one.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_r <= ST_SLEEP;
        end else begin
            case (st_r)
                ST_SLEEP: begin
                    if (!sleep && sel_q[1]) begin
                        st_r <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (sleep) begin
                        st_r <= ST_SLEEP;
                    end else if (sel_fall) begin
                        st_r <= ST_FRAME;
                    end
                end
                ST_FRAME: begin
                    if (sleep) begin
                        st_r <= ST_SLEEP;
                    end else if (sel_rise) begin
                        st_r <= ST_IDLE;
                    end
                end
                default: st_r <= ST_SLEEP;
            endcase
        end
    end

    // Input shifting on falling clock edges, MSB first.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_r   <= 5'h00;
            in_sr_r <= 16'h0000;
        end else if (sel_fall) begin
            cnt_r   <= 5'h00;
            in_sr_r <= 16'h0000;
        end else if (in_frame && !sel_q[1] && sclk_fall) begin
            in_sr_r <= {in_sr_r[FRAME_W-2:0], sdi_q[1]};
            if (cnt_r != CNT_SAT) begin
                cnt_r <= cnt_r + 5'h01;
            end
        end
    end

    // Once the fifth bit is in, the address is known; the bank registers the
    // read a cycle later, well before the next rising clock edge.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cap1_r <= 1'b0;
            cap2_r <= 1'b0;
        end else begin
            cap1_r <= in_frame && sclk_fall && (cnt_r == CMD_BITS - 5'h01);
            cap2_r <= cap1_r;
        end
    end

    // Output shifting on rising clock edges; the command slots stay released.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            out_sr_r  <= 11'h000;
            sdo_rel_r <= 1'b1;
        end else if (!in_frame || sel_q[1]) begin
            sdo_rel_r <= 1'b1;
        end else if (cap2_r) begin
            out_sr_r  <= rd_data;
        end else if (sclk_rise) begin
            if (cnt_r >= CMD_BITS && cnt_r < FRAME_BITS) begin
                sdo_rel_r <= out_sr_r[DATA_W-1];
                out_sr_r  <= {out_sr_r[DATA_W-2:0], 1'b0};
            end else begin
                sdo_rel_r <= 1'b1;
            end
        end
    end

    // The pin is only ever pulled low; a high comes from the external pull-up.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sdo_low_r <= 1'b0;
        end else begin
            sdo_low_r <= 1'b0;
        end
    end

    // Frame close: commit a good write, flag a bad length.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_en_r   <= 1'b0;
            wr_addr_r <= 4'h0;
            wr_data_r <= 11'h000;
            clr_r     <= 1'b0;
            err_r     <= 1'b0;
        end else begin
            wr_en_r <= 1'b0;
            clr_r   <= 1'b0;
            err_r   <= 1'b0;
            if (in_frame && sel_rise && !sleep) begin
                if (!f_ok) begin
                    err_r <= 1'b1;
                end else if (f_write && wr_allow) begin
                    wr_en_r   <= 1'b1;
                    wr_addr_r <= f_addr;
                    wr_data_r <= in_sr_r[DATA_W-1:0];
                    clr_r     <= (f_addr == ADDR_DRV) && in_sr_r[LATCHED_FAULT_CLEAR_POS];
                end
            end
        end
    end

    spi_reg_bank u_bank (
        .i_clk       (i_clk),
        .i_rstn      (i_rstn),
        .i_sleep     (sleep),
        .i_wr_en     (wr_en_r),
        .i_wr_addr   (wr_addr_r),
        .i_wr_data   (wr_data_r),
        .i_lock_only (locked),
        .i_rd_addr   (in_sr_r[3:0]),
        .i_status1   (i_fault_status_primary),
        .i_status2   (i_gate_fault_status_secondary),
        .o_rd_data   (rd_data),
        .o_drv       (o_driver_control),
        .o_gdhs      (o_gate_drive_high_side),
        .o_gdls      (o_gate_drive_low_side),
        .o_ocp       (o_overcurrent_control),
        .o_csa       (o_current_amp_control),
        .o_cal       (o_calibration_mode_control)
    );

    assign o_serial_data_out      = sdo_low_r;
    assign o_serial_data_out_oe_n = sdo_rel_r;
    assign o_latched_fault_clear  = clr_r;
    assign o_frame_error          = err_r;

    // Checks.
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    sequence s_frame_close;
        in_frame && sel_rise && !sleep;
    endsequence

    sequence s_good_write;
        s_frame_close ##0 f_ok && f_write && wr_allow;
    endsequence

    property p_desel_release;
        sel_q[1] |=> sdo_rel_r;
    endproperty
    a_desel_release: assert property (p_desel_release)
        else $error("Serial output driven while deselected.");

    property p_no_start;
        !in_frame |=> sdo_rel_r && !cap1_r;
    endproperty
    a_no_start: assert property (p_no_start)
        else $error("Port active without a frame.");

    property p_cmd_slots;
        (in_frame && cnt_r < CMD_BITS) |-> sdo_rel_r;
    endproperty
    a_cmd_slots: assert property (p_cmd_slots)
        else $error("Output pulled low during command bits.");

    property p_open_drain;
        o_serial_data_out == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("Serial output drove a high level.");

    property p_frame_err;
        s_frame_close ##0 !f_ok |=> o_frame_error && !wr_en_r;
    endproperty
    a_frame_err: assert property (p_frame_err)
        else $error("Bad frame length not flagged or was written.");

    property p_commit;
        s_good_write |=> wr_en_r && wr_addr_r == $past(f_addr);
    endproperty
    a_commit: assert property (p_commit)
        else $error("Good write frame not committed.");

    property p_read_only;
        wr_en_r |-> wr_addr_r >= ADDR_DRV;
    endproperty
    a_read_only: assert property (p_read_only)
        else $error("Write reached a status register.");

    property p_lock;
        (wr_en_r && $past(locked)) |-> wr_addr_r == ADDR_GDHS;
    endproperty
    a_lock: assert property (p_lock)
        else $error("Write passed while locked.");

    property p_clear_pulse;
        o_latched_fault_clear |=> !o_latched_fault_clear && !o_driver_control[LATCHED_FAULT_CLEAR_POS];
    endproperty
    a_clear_pulse: assert property (p_clear_pulse)
        else $error("Fault clear did not self-clear.");

    property p_sleep;
        sleep |=> o_driver_control == DEF_DRV && o_gate_drive_high_side == DEF_GDHS && st_r == ST_SLEEP;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("Sleep did not restore defaults.");

    property p_restart;
        sel_fall |=> cnt_r == 5'h00 && in_sr_r == 16'h0000;
    endproperty
    a_restart: assert property (p_restart)
        else $error("Frame counter not restarted.");

    property p_msb_first;
        (in_frame && !sel_q[1] && sclk_fall && !sel_fall) |=> in_sr_r[0] == $past(sdi_q[1]);
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("Input bit not shifted in at the bottom.");

    property p_read_data;
        (cap2_r && in_frame && !sel_q[1]) |=> out_sr_r == $past(rd_data);
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("Returned data not loaded from the register.");

endmodule : spi_port

// *** sim/spi_master_model.sv ***
module spi_master_model (
    // Line as seen at the pin, pull-up included.
    input  wire logic i_sdo_wire,
    // Lines driven toward the port.
    output logic      o_select_n,
    output logic      o_sclk,
    output logic      o_sdi
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        o_select_n = 1'b1;
        o_sclk     = 1'b0;
        o_sdi      = 1'b0;
    end

    // The 13 ns skew keeps link edges away from the system clock edges.
    task automatic xfer(input int nbits, input int half, input logic [15:0] word, output logic [15:0] rx);
        rx = 16'h0000;
        #13;
        o_select_n = 1'b0;
        #(half);
        for (int i = 0; i < nbits; i++) begin
            o_sclk = 1'b1;
            o_sdi  = word[15 - (i % 16)];
            #(half);
            o_sclk = 1'b0;
            rx     = {rx[14:0], i_sdo_wire};
            #(half);
        end
        o_select_n = 1'b1;
        o_sdi      = ~o_sdi;
        #(half);
        // Clock and data toggle while deselected; the port must ignore them.
        repeat (3) begin
            o_sclk = 1'b1;
            o_sdi  = ~o_sdi;
            #(half);
            o_sclk = 1'b0;
            #(half);
        end
        #1000;
    endtask : xfer
endmodule : spi_master_model

// *** sim/gate_driver_spi_register_port_tb_top.sv ***
module gate_driver_spi_register_port_tb_top
    import spi_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic              i_clk = 1'b0;
    logic              i_rstn;
    logic              i_enable;
    logic              select_n;
    logic              sclk;
    logic              serial_data_in;
    logic              serial_data_out;
    logic              sdo_oe_n;
    logic              sdo_wire;
    logic [DATA_W-1:0] status1;
    logic [DATA_W-1:0] status2;
    logic [DATA_W-1:0] drv, gdhs, gdls, ocp, csa, cal;
    logic              clr_pulse;
    logic              err_pulse;
    logic [DATA_W-1:0] mreg [8];
    logic [31:0]       seed;
    logic [31:0]       r;
    logic [31:0]       s;
    int                failures = 0;
    int                checked = 0;
    int                n_err = 0;
    int                n_clr = 0;
    int                seen_err = 0;
    int                seen_clr = 0;

    always #50 i_clk = ~i_clk;
    assign sdo_wire = sdo_oe_n ? 1'b1 : serial_data_out;

    spi_port dut (
        .i_clk                         (i_clk),
        .i_rstn                        (i_rstn),
        .i_enable                      (i_enable),
        .i_serial_select_n             (select_n),
        .i_sclk                        (sclk),
        .i_serial_data_in              (serial_data_in),
        .o_serial_data_out             (serial_data_out),
        .o_serial_data_out_oe_n        (sdo_oe_n),
        .i_fault_status_primary        (status1),
        .i_gate_fault_status_secondary (status2),
        .o_driver_control              (drv),
        .o_gate_drive_high_side        (gdhs),
        .o_gate_drive_low_side         (gdls),
        .o_overcurrent_control         (ocp),
        .o_current_amp_control         (csa),
        .o_calibration_mode_control    (cal),
        .o_latched_fault_clear         (clr_pulse),
        .o_frame_error                 (err_pulse)
    );

    spi_master_model master (
        .i_sdo_wire (sdo_wire),
        .o_select_n (select_n),
        .o_sclk     (sclk),
        .o_sdi      (serial_data_in)
    );

    always @(posedge i_clk) begin
        if (err_pulse === 1'b1) begin
            seen_err++;
        end
        if (clr_pulse === 1'b1) begin
            seen_clr++;
        end
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic chk_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_cnt(input int got, input int exp);
        checked++;
        if (got != exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_cnt

    task automatic results();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    task automatic check_regs();
        chk_word(drv, mreg[2]);
        chk_word(gdhs, mreg[3]);
        chk_word(gdls, mreg[4]);
        chk_word(ocp, mreg[5]);
        chk_word(csa, mreg[6]);
        chk_word(cal, mreg[7]);
        chk_word({10'h000, sdo_oe_n}, 11'h001);
    endtask : check_regs

    task automatic do_frame(input int nbits, input int half, input logic rw, input logic [3:0] a,
                            input logic [DATA_W-1:0] d);
        logic [15:0]       rx;
        logic [DATA_W-1:0] expd;
        logic              locked;
        @(posedge i_clk);
        expd = (a == ADDR_FAULT1) ? status1 : (a == ADDR_FAULT2) ? status2 : 11'h000;
        if (a > ADDR_FAULT2 && a <= ADDR_CAL) begin
            expd = mreg[a[2:0]];
        end
        locked = (mreg[3][LOCK_MSB:LOCK_LSB] == LOCK_SET);
        master.xfer(nbits, half, {rw, a, d}, rx);
        if (nbits != 16) begin
            n_err++;
        end else if (rw == RW_WRITE) begin
            chk_word(rx[DATA_W-1:0], expd);
            if (locked) begin
                if (a == ADDR_GDHS) begin
                    mreg[3][LOCK_MSB:LOCK_LSB] = d[LOCK_MSB:LOCK_LSB];
                end
            end else if (a == ADDR_DRV) begin
                mreg[2] = d & 11'h7fe;
                n_clr += int'(d[LATCHED_FAULT_CLEAR_POS]);
            end else if (a == ADDR_CAL) begin
                mreg[7] = d & CAL_MASK;
            end else if (a >= ADDR_GDHS && a < ADDR_CAL) begin
                mreg[a[2:0]] = d;
            end
        end else begin
            chk_word(rx[DATA_W-1:0], expd);
        end
        check_regs();
        chk_cnt(seen_err, n_err);
        chk_cnt(seen_clr, n_clr);
    endtask : do_frame

    initial begin
        i_rstn   = 1'b0;
        i_enable = 1'b1;
        status1  = 11'h5a5;
        status2  = 11'h2c3;
        seed     = 32'h8;
        foreach (mreg[i]) mreg[i] = 11'h000;
        repeat (12) @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (10) @(posedge i_clk);
        for (int a = 0; a < 10; a++) begin
            do_frame(16, 400, 1'b1, 4'(a), 11'h7ff);
        end
        for (int k = 0; k < 24; k++) begin
            r = xs();
            s = xs();
            @(posedge i_clk);
            status1 <= s[10:0];
            status2 <= s[21:11];
            do_frame(16, 400, r[4], {1'b0, r[2:0]}, r[15:5]);
        end
        // Clear a possible random lock so the fixed cases start unlocked.
        do_frame(16, 400, RW_WRITE, ADDR_GDHS, 11'h000);
        do_frame(16, 400, RW_WRITE, ADDR_DRV, 11'h5a3);
        do_frame(16, 400, RW_WRITE, ADDR_FAULT1, 11'h7ff);
        do_frame(16, 400, RW_WRITE, ADDR_FAULT2, 11'h7ff);
        do_frame(16, 400, RW_WRITE, ADDR_GDLS, 11'h2a5);
        for (int k = 0; k < 3; k++) begin
            do_frame((k == 0) ? 15 : (k == 1) ? 17 : 0, 400, RW_WRITE, ADDR_GDLS, 11'h0f0);
        end
        do_frame(16, 400, 1'b1, ADDR_GDLS, 11'h000);
        do_frame(16, 400, RW_WRITE, ADDR_GDHS, {LOCK_SET, 8'h5c});
        do_frame(16, 400, RW_WRITE, ADDR_OCP, 11'h3c3);
        do_frame(16, 400, RW_WRITE, ADDR_DRV, 11'h001);
        do_frame(16, 400, RW_WRITE, ADDR_GDHS, 11'h3ff);
        do_frame(16, 400, RW_WRITE, ADDR_OCP, 11'h3c3);
        do_frame(16, 400, RW_WRITE, ADDR_CAL, 11'h7ff);
        @(posedge i_clk);
        i_enable <= 1'b0;
        repeat (8) @(posedge i_clk);
        foreach (mreg[i]) mreg[i] = 11'h000;
        check_regs();
        i_enable <= 1'b1;
        repeat (10) @(posedge i_clk);
        do_frame(16, 400, 1'b1, ADDR_OCP, 11'h000);
        results();
    end

    initial begin
        repeat (90000) @(posedge i_clk);
        failures++;
        results();
    end
endmodule : gate_driver_spi_register_port_tb_top
